// ### core/ilp_ctrl.sv
// Interrupt priority, mask, idle and power-down control
`timescale 1ns/1ps

// How it works
// - Eleven interrupt sources plus reset handled
// - Fixed priority order with documented vectors
// - Pending ANDed with mask, highest wins
// - Power-down and reset ignore mask register
// - Three request pins selectable edge or level
// - Level pins fixed; edge pin software settable
// - Mask write blocks interrupts one cycle
// - Control bit selects nested or sequential servicing
// - Write-only force/clear register edits pending
// - Twelve-deep status stack pushed and popped
// - Global enable gates all including power-down
// - Global enable set after reset
// - Port B pins become two requests, flags
// - Software bit starts power-down, pin wakes it; ack
// - Power-down interrupt nonmaskable, edge sensitive
// - Recovery within 100 or 4096 input cycles
// - Context bit chooses resume or clean; reset ends
// - Idle waits for unmasked interrupt, then continues
// - Slow idle divides clock by 16..128
// - Wake from slow idle within n cycles
// - Clock output toggles unless disable bit set or in power-down
// - Flag-shared pins interrupt when asserted either way
module ilp_ctrl #(
    parameter int CRYSTAL_PIN_WAIT = ilp_pkg::CRYSTAL_PIN_CYC
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request pins, active low; port B flag input active high
    input wire logic edge_or_level_request_n,
    input wire logic level_request_a_n,
    input wire logic level_request_b_n,
    input wire logic edge_only_request_n,
    input wire logic port_b_shared_request_rx_n,
    input wire logic port_b_shared_request_tx_n,
    input wire logic powerdown_request_pin_n,
    input wire logic port_b_flag_in,
    // Internal sources, one-cycle pulses
    input wire logic timer_irq,
    input wire logic byte_dma_irq,
    input wire logic spa_tx_irq,
    input wire logic spa_rx_irq,
    input wire logic spb_tx_irq,
    input wire logic spb_rx_irq,
    // Sequencer side
    output logic irq_req,
    output logic [ilp_pkg::VEC_W-1:0] irq_vector,
    output logic core_run,
    output logic [ilp_pkg::CTRL_W-1:0] stack_top,
    output logic stack_full,
    output logic stack_empty,
    output logic ctx_clear,
    output logic port_b_flag_out,
    // Power and clock
    output logic powerdown_ack_pin,
    output logic clock_output_pin,
    output logic core_clk_en
);
    import ilp_pkg::*;

    typedef enum logic [1:0] {
        ILP_RUN = 2'b00,
        ILP_IDLE = 2'b01,
        ILP_PWD = 2'b10,
        ILP_WAKE = 2'b11
    } ilp_state_e;

    function automatic logic [VEC_W-1:0] ilp_vec(input logic [3:0] idx);
        logic [VEC_W-1:0] v;
        v = VEC_TIMER;
        unique case (idx)
            4'h0: v = VEC_PWD;
            4'h1: v = VEC_ELR;
            4'h2: v = VEC_LVB;
            4'h3: v = VEC_LVA;
            4'h4: v = VEC_SPA_TX;
            4'h5: v = VEC_SPA_RX;
            4'h6: v = VEC_EDGE;
            4'h7: v = VEC_BYTE_DMA;
            4'h8: v = VEC_SPB_TX;
            4'h9: v = VEC_SPB_RX;
            default: v = VEC_TIMER;
        endcase
        return v;
    endfunction

    // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
    assign pin_raw = {~powerdown_request_pin_n, ~port_b_shared_request_tx_n,
                      ~port_b_shared_request_rx_n, ~edge_only_request_n,
                      ~level_request_b_n, ~level_request_a_n,
                      ~edge_or_level_request_n};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            pin_ff <= '0;
        end else begin
            s1_ff <= pin_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < NPIN; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    pin_ff[i] <= s3_ff[i];
                end
            end
        end
    end
    logic [NPIN-1:0] pin_prev_ff;
    logic [NPIN-1:0] pin_rise;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_ff <= '0;
        end else begin
            pin_prev_ff <= pin_ff;
        end
    end
    assign pin_rise = pin_ff & ~pin_prev_ff;

    // Software state
    logic [NUM_SRC-1:0] mask_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic gie_ff;
    logic mask_blk_ff;
    logic [NUM_SRC-1:0] pend_ff, nxt_pend;
    logic [NUM_SRC-1:0] active_ff;
    logic [NUM_SRC-1:0] live;
    ilp_state_e state_ff;
    logic wr, rd;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;

    logic cmd_ena, cmd_dis, cmd_rti, cmd_idle, cmd_pwd, cmd_ack, cmd_push, cmd_pop;
    logic [1:0] cmd_div;
    logic wr_cmd, wr_force;
    assign wr_cmd = wr && paddr == ADDR_CMD;
    assign wr_force = wr && paddr == ADDR_FORCE;
    assign cmd_ena = wr_cmd && pwdata[CMD_ENA];
    assign cmd_dis = wr_cmd && pwdata[CMD_DIS];
    assign cmd_rti = wr_cmd && pwdata[CMD_RTI];
    assign cmd_idle = wr_cmd && pwdata[CMD_IDLE];
    assign cmd_pwd = wr_cmd && pwdata[CMD_PWD_ENTER];
    assign cmd_div = pwdata[CMD_DIV_LO+:2];
    assign cmd_ack = wr_cmd && pwdata[CMD_ACK];
    assign cmd_push = wr_cmd && pwdata[CMD_PUSH];
    assign cmd_pop = wr_cmd && pwdata[CMD_POP];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= MASK_RST;
            ctrl_ff <= CTRL_RST;
            mask_blk_ff <= 1'b0;
        end else begin
            mask_blk_ff <= wr && paddr == ADDR_MASK;
            if (wr && paddr == ADDR_MASK) begin
                mask_ff <= pwdata[NUM_SRC-1:0];
            end
            if (wr && paddr == ADDR_CTRL) begin
                ctrl_ff <= pwdata[CTRL_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_ff <= 1'b1;
        end else if (cmd_dis) begin
            gie_ff <= 1'b0;
        end else if (cmd_ena) begin
            gie_ff <= 1'b1;
        end
    end

    // Port B requests share the port's vectors when reconfigured
    logic spb_mode, spb_tx_src, spb_rx_src, elr_src;
    assign spb_mode = ctrl_ff[CTRL_SPB_IRQ];
    assign spb_tx_src = ctrl_ff[CTRL_SPB_TX_EDGE] ? pin_rise[5] : pin_ff[5];
    assign spb_rx_src = ctrl_ff[CTRL_SPB_RX_EDGE] ? pin_rise[4] : pin_ff[4];
    assign elr_src = ctrl_ff[CTRL_ELR_EDGE] ? pin_rise[0] : pin_ff[0];

    // Live level sources feed selection each cycle without latching
    always_comb begin
        live = '0;
        live[SRC_ELR] = !ctrl_ff[CTRL_ELR_EDGE] && pin_ff[0];
        live[SRC_LVB] = pin_ff[2];
        live[SRC_LVA] = pin_ff[1];
        live[SRC_SPB_TX] = spb_mode && !ctrl_ff[CTRL_SPB_TX_EDGE] && pin_ff[5];
        live[SRC_SPB_RX] = spb_mode && !ctrl_ff[CTRL_SPB_RX_EDGE] && pin_ff[4];
    end

    // Selection
    logic [NUM_SRC-1:0] req, elig;
    logic [3:0] sel_idx;
    logic sel_ok;
    logic [NUM_SRC-1:0] eff_mask;
    always_comb begin
        eff_mask = mask_ff;
        eff_mask[SRC_PWD] = 1'b1;
        req = (pend_ff | live) & eff_mask;
        elig = req;
        if (ctrl_ff[CTRL_NEST]) begin
            // Only sources above every active one may preempt
            for (int i = 0; i < NUM_SRC; i++) begin
                if (active_ff[i]) begin
                    for (int j = i; j < NUM_SRC; j++) begin
                        elig[j] = 1'b0;
                    end
                end
            end
        end else if (|active_ff) begin
            elig = '0;
        end
        sel_idx = 4'h0;
        sel_ok = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (elig[i]) begin
                sel_idx = 4'(i);
                sel_ok = 1'b1;
            end
        end
        if (!gie_ff || mask_blk_ff || irq_req) begin
            sel_ok = 1'b0;
        end
    end

    logic accept;
    assign accept = sel_ok && (state_ff == ILP_RUN || state_ff == ILP_IDLE) && core_clk_en;

    // Pending latches; hardware set wins over software clear
    always_comb begin
        nxt_pend = pend_ff;
        if (wr_force) begin
            nxt_pend = (pend_ff & ~pwdata[NUM_SRC+15:16]) | pwdata[NUM_SRC-1:0];
        end
        if (accept) begin
            nxt_pend[sel_idx] = 1'b0;
        end
        nxt_pend[SRC_PWD] = nxt_pend[SRC_PWD] | pin_rise[6];
        nxt_pend[SRC_ELR] = nxt_pend[SRC_ELR] | (ctrl_ff[CTRL_ELR_EDGE] & elr_src);
        nxt_pend[SRC_EDGE] = nxt_pend[SRC_EDGE] | pin_rise[3];
        nxt_pend[SRC_SPA_TX] = nxt_pend[SRC_SPA_TX] | spa_tx_irq;
        nxt_pend[SRC_SPA_RX] = nxt_pend[SRC_SPA_RX] | spa_rx_irq;
        nxt_pend[SRC_BYTE_DMA] = nxt_pend[SRC_BYTE_DMA] | byte_dma_irq;
        nxt_pend[SRC_TIMER] = nxt_pend[SRC_TIMER] | timer_irq;
        nxt_pend[SRC_SPB_TX] = nxt_pend[SRC_SPB_TX] |
            (spb_mode ? (ctrl_ff[CTRL_SPB_TX_EDGE] & spb_tx_src) : spb_tx_irq);
        nxt_pend[SRC_SPB_RX] = nxt_pend[SRC_SPB_RX] |
            (spb_mode ? (ctrl_ff[CTRL_SPB_RX_EDGE] & spb_rx_src) : spb_rx_irq);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // Vector hand-off; held until the sequencer acknowledges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= 1'b0;
            irq_vector <= VEC_RESET;
        end else if (accept) begin
            irq_req <= 1'b1;
            irq_vector <= ilp_vec(sel_idx);
        end else if (cmd_ack) begin
            irq_req <= 1'b0;
        end
    end

    // Status stack: entries hold the accepted source index or the pushed value
    logic [CTRL_W-1:0] stk_mem [STACK_DEPTH];
    logic [3:0] sp_ff;
    logic push, pop;
    assign push = (accept || cmd_push) && sp_ff < 4'(STACK_DEPTH);
    assign pop = (cmd_rti || cmd_pop) && sp_ff != 4'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_ff <= 4'h0;
            active_ff <= '0;
        end else begin
            if (push && !pop) begin
                sp_ff <= sp_ff + 4'h1;
            end else if (pop && !push) begin
                sp_ff <= sp_ff - 4'h1;
            end
            if (accept) begin
                active_ff[sel_idx] <= 1'b1;
            end else if (cmd_rti) begin
                // Retire the highest-priority running handler
                for (int i = NUM_SRC - 1; i >= 0; i--) begin
                    if (active_ff[i] && (active_ff & ((NUM_SRC)'(1) << i) - 1'b1) == '0) begin
                        active_ff[i] <= 1'b0;
                    end
                end
            end
        end
    end
    always_ff @(posedge pclk) begin
        if (push) begin
            stk_mem[sp_ff] <= {4'h0, accept ? sel_idx : pwdata[19:16]};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_top <= '0;
            stack_full <= 1'b0;
            stack_empty <= 1'b1;
        end else begin
            stack_top <= (sp_ff == 4'h0) ? '0 : stk_mem[sp_ff - 4'h1];
            stack_full <= sp_ff == 4'(STACK_DEPTH);
            stack_empty <= sp_ff == 4'h0;
        end
    end

    // Idle, slow idle and power-down sequencing
    logic [7:0] div_n_ff, div_cnt_ff;
    logic [13:0] wake_cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ILP_RUN;
            div_n_ff <= 8'h00;
            wake_cnt_ff <= '0;
            ctx_clear <= 1'b0;
            powerdown_ack_pin <= 1'b0;
        end else begin
            unique case (state_ff)
                ILP_RUN: begin
                    ctx_clear <= 1'b0;
                    if (cmd_pwd) begin
                        state_ff <= ILP_PWD;
                        powerdown_ack_pin <= 1'b1;
                    end else if (cmd_idle) begin
                        state_ff <= ILP_IDLE;
                        div_n_ff <= wr_cmd && pwdata[CMD_DIV_LO+2] ?
                            (8'h10 << cmd_div) : 8'h00;
                    end
                end
                ILP_IDLE: begin
                    if (accept) begin
                        state_ff <= ILP_RUN;
                        div_n_ff <= 8'h00;
                    end
                end
                ILP_PWD: begin
                    if (pin_rise[6] || (wr_force && pwdata[SRC_PWD])) begin
                        state_ff <= ILP_WAKE;
                        wake_cnt_ff <= ctrl_ff[CTRL_CRYSTAL_PIN_OFF] ?
                            14'(CRYSTAL_PIN_WAIT) : 14'(RECOVER_CYC);
                    end
                end
                ILP_WAKE: begin
                    if (wake_cnt_ff <= 14'h0001) begin
                        state_ff <= ILP_RUN;
                        powerdown_ack_pin <= 1'b0;
                        ctx_clear <= ctrl_ff[CTRL_CTX];
                    end else begin
                        wake_cnt_ff <= wake_cnt_ff - 14'h0001;
                    end
                end
            endcase
        end
    end

    // Core clock divider; the processor cycle is the pclk cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_ff <= 8'h00;
            core_clk_en <= 1'b1;
            clock_output_pin <= 1'b0;
        end else begin
            if (div_n_ff == 8'h00 || div_cnt_ff == div_n_ff - 8'h01) begin
                div_cnt_ff <= 8'h00;
            end else begin
                div_cnt_ff <= div_cnt_ff + 8'h01;
            end
            core_clk_en <= div_n_ff == 8'h00 || div_cnt_ff == div_n_ff - 8'h01;
            if (!ctrl_ff[CTRL_CLKO_DIS] && state_ff != ILP_PWD) begin
                clock_output_pin <= (div_n_ff == 8'h00) ? ~clock_output_pin :
                    (div_cnt_ff == 8'h00 || div_cnt_ff == div_n_ff >> 1) ?
                    ~clock_output_pin : clock_output_pin;
            end else begin
                clock_output_pin <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_run <= 1'b1;
            port_b_flag_out <= 1'b0;
        end else begin
            core_run <= state_ff == ILP_RUN;
            port_b_flag_out <= spb_mode && port_b_flag_in;
        end
    end

    // APB read path, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == ADDR_MASK || paddr == ADDR_CTRL ||
                paddr == ADDR_FORCE || paddr == ADDR_CMD || paddr == ADDR_STATUS ||
                paddr == ADDR_PEND);
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    ADDR_MASK: prdata <= 32'(mask_ff);
                    ADDR_CTRL: prdata <= 32'(ctrl_ff);
                    ADDR_STATUS: prdata <= {20'h00000, sp_ff, 2'(state_ff), 1'b0,
                        powerdown_ack_pin, mask_blk_ff, irq_req, core_clk_en, gie_ff};
                    ADDR_PEND: prdata <= {5'h00, active_ff, 5'h00, pend_ff | live};
                    default: prdata <= '0;
                endcase
            end
        end
    end
endmodule

// ### core/ilp_pkg.sv
// Package: constants for the interrupt and low power controller
package ilp_pkg;
    localparam int NUM_SRC = 11;
    localparam int VEC_W = 16;
    // Source index in descending priority
    localparam int SRC_PWD = 0;
    localparam int SRC_ELR = 1;
    localparam int SRC_LVB = 2;
    localparam int SRC_LVA = 3;
    localparam int SRC_SPA_TX = 4;
    localparam int SRC_SPA_RX = 5;
    localparam int SRC_EDGE = 6;
    localparam int SRC_BYTE_DMA = 7;
    localparam int SRC_SPB_TX = 8;
    localparam int SRC_SPB_RX = 9;
    localparam int SRC_TIMER = 10;
    localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
    localparam logic [VEC_W-1:0] VEC_PWD = 16'h002C;
    localparam logic [VEC_W-1:0] VEC_ELR = 16'h0004;
    localparam logic [VEC_W-1:0] VEC_LVB = 16'h0008;
    localparam logic [VEC_W-1:0] VEC_LVA = 16'h000C;
    localparam logic [VEC_W-1:0] VEC_SPA_TX = 16'h0010;
    localparam logic [VEC_W-1:0] VEC_SPA_RX = 16'h0014;
    localparam logic [VEC_W-1:0] VEC_EDGE = 16'h0018;
    localparam logic [VEC_W-1:0] VEC_BYTE_DMA = 16'h001C;
    localparam logic [VEC_W-1:0] VEC_SPB_TX = 16'h0020;
    localparam logic [VEC_W-1:0] VEC_SPB_RX = 16'h0024;
    localparam logic [VEC_W-1:0] VEC_TIMER = 16'h0028;
    // APB register map (byte addresses)
    localparam logic [7:0] ADDR_MASK = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_FORCE = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_PEND = 8'h14;
    // Control register fields
    localparam int CTRL_ELR_EDGE = 0;
    localparam int CTRL_SPB_TX_EDGE = 1;
    localparam int CTRL_SPB_RX_EDGE = 2;
    localparam int CTRL_NEST = 3;
    localparam int CTRL_SPB_IRQ = 4;
    localparam int CTRL_CTX = 5;
    localparam int CTRL_CRYSTAL_PIN_OFF = 6;
    localparam int CTRL_CLKO_DIS = 7;
    localparam int CTRL_W = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [NUM_SRC-1:0] MASK_RST = 11'h000;
    // Command register fields: one-shot actions
    localparam int CMD_ENA = 0;
    localparam int CMD_DIS = 1;
    localparam int CMD_RTI = 2;
    localparam int CMD_IDLE = 3;
    localparam int CMD_PWD_ENTER = 4;
    localparam int CMD_DIV_LO = 5;
    localparam int CMD_ACK = 8;
    localparam int CMD_PUSH = 9;
    localparam int CMD_POP = 10;
    // Timing in input clock cycles; the input clock runs at half the cycle rate
    localparam int CLK_MHZ = 200;
    localparam int RECOVER_IN_CYC = 100;
    localparam int CRYSTAL_PIN_IN_CYC = 4096;
    localparam int RECOVER_CYC = RECOVER_IN_CYC * 2;
    localparam int CRYSTAL_PIN_CYC = CRYSTAL_PIN_IN_CYC * 2;
    localparam int STACK_DEPTH = 12;
endpackage

// ### verif/ilp_ctrl_checker.sv
// Port-level assertions for the interrupt and low power controller
`timescale 1ns/1ps
module ilp_ctrl_checker #(
    parameter int CRYSTAL_PIN_WAIT = 64
) (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencer and clock side
    input wire logic irq_req,
    input wire logic [ilp_pkg::VEC_W-1:0] irq_vector,
    input wire logic stack_full,
    input wire logic stack_empty,
    input wire logic clock_output_pin
);
    import ilp_pkg::*;
    logic wr_acc;
    logic gie_ff;
    logic clko_dis_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_acc = psel && penable && pwrite && pready;
    // Shadows, since enable and clock-out state are not visible at the ports
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_ff <= 1'b1;
        end else if (wr_acc && paddr == ADDR_CMD && (pwdata[CMD_ENA] || pwdata[CMD_DIS])) begin
            gie_ff <= !pwdata[CMD_DIS];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clko_dis_ff <= 1'b0;
        end else if (wr_acc && paddr == ADDR_CTRL) begin
            clko_dis_ff <= pwdata[CTRL_CLKO_DIS];
        end
    end
    sequence s_mask_wr;
        wr_acc && paddr == ADDR_MASK;
    endsequence
    sequence s_gie_off;
        !gie_ff && !irq_req;
    endsequence
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("no pready in access cycle");
    a_slverr_unmapped: assert property (psel && penable && paddr > ADDR_PEND |-> pslverr)
        else $error("unmapped access not refused");
    a_vec_legal: assert property ($rose(irq_req) |-> irq_vector != VEC_RESET &&
        irq_vector[1:0] == 2'h0 && irq_vector <= VEC_PWD)
        else $error("illegal vector raised");
    a_req_holds: assert property (irq_req && !(wr_acc && paddr == ADDR_CMD &&
        pwdata[CMD_ACK]) |=> irq_req && $stable(irq_vector))
        else $error("request dropped before ack");
    a_mask_block: assert property (s_mask_wr |-> ##2 !$rose(irq_req))
        else $error("interrupt taken right after mask write");
    a_gie_gate: assert property (s_gie_off |=> !irq_req)
        else $error("interrupt taken while disabled");
    a_stack_flags: assert property (!(stack_full && stack_empty))
        else $error("stack full and empty at once");
    a_clock_output_pin_hold: assert property (clko_dis_ff && $past(clko_dis_ff, 2) |->
        $stable(clock_output_pin))
        else $error("clock output moves while disabled");
endmodule

bind ilp_ctrl ilp_ctrl_checker #(.CRYSTAL_PIN_WAIT(CRYSTAL_PIN_WAIT)) i_ilp_ctrl_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .irq_vector(irq_vector), .stack_full(stack_full),
    .stack_empty(stack_empty), .clock_output_pin(clock_output_pin));

// ### verif/ilp_src_model.sv
// Model of the external request sources facing the controller
`timescale 1ns/1ps
module ilp_src_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requests wanted by the bench, active high, and core busy
    input wire logic [6:0] want,
    input wire logic irq_req,
    // Request pins, active low, pulled up when released
    output logic [6:0] pin_n
);
    logic [6:0] held_ff;
    // New requests wait while the core is busy, so sources never outrun it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_ff <= 7'h00;
        end else begin
            held_ff <= irq_req ? (held_ff & want) : want;
        end
    end
    assign pin_n = ~held_ff;
endmodule

// ### verif/ilp_ctrl_test.sv
// Self-checking bench for the interrupt and low power controller
`timescale 1ns/1ps
module ilp_ctrl_test;
    import ilp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [6:0] want = 7'h00;
    logic [5:0] pulse = 6'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, irq_req, core_run, stack_empty, core_clk_en;
    logic [6:0] pin_n;
    logic [VEC_W-1:0] irq_vector;
    int n_errors = 0;
    int checks_done = 0;
    always #2.5 pclk = ~pclk;
    ilp_src_model i_ilp_src_model (.pclk(pclk), .presetn(presetn), .want(want),
        .irq_req(irq_req), .pin_n(pin_n));
    ilp_ctrl #(.CRYSTAL_PIN_WAIT(64)) i_ilp_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .edge_or_level_request_n(pin_n[0]), .level_request_a_n(pin_n[1]),
        .level_request_b_n(pin_n[2]), .edge_only_request_n(pin_n[3]),
        .port_b_shared_request_rx_n(pin_n[4]), .port_b_shared_request_tx_n(pin_n[5]),
        .powerdown_request_pin_n(pin_n[6]), .port_b_flag_in(1'b0),
        .timer_irq(pulse[0]), .byte_dma_irq(pulse[1]), .spa_tx_irq(pulse[2]),
        .spa_rx_irq(pulse[3]), .spb_tx_irq(pulse[4]), .spb_rx_irq(pulse[5]),
        .irq_req(irq_req), .irq_vector(irq_vector), .core_run(core_run), .stack_top(),
        .stack_full(), .stack_empty(stack_empty), .ctx_clear(), .port_b_flag_out(),
        .powerdown_ack_pin(), .clock_output_pin(), .core_clk_en(core_clk_en));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Taken in the edge's own step, before the slave's updates land
        @(posedge pclk iff pready === 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input int b);
        apb(1'b1, ADDR_CMD, 32'h1 << b);
    endtask
    task automatic frc(input int s);
        apb(1'b1, ADDR_FORCE, 32'h1 << s);
    endtask
    task automatic serve();
        cmd(CMD_ACK);
        cmd(CMD_RTI);
    endtask
    task automatic wait_irq(input logic [VEC_W-1:0] v);
        int n;
        n = 0;
        while (irq_req !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk(irq_req, 1'b1);
        chk(irq_vector, v);
    endtask
    task automatic quiet();
        repeat (12) @(posedge pclk);
        chk(irq_req, 1'b0);
    endtask
    task automatic t_reset();
        chk({irq_req, core_run, stack_empty, core_clk_en}, 4'b0111);
        chk(irq_vector, VEC_RESET);
        apb(1'b0, ADDR_MASK, 32'h0);
        chk(rd, MASK_RST);
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("t_reset end");
    endtask
    task automatic t_prio();
        apb(1'b1, ADDR_MASK, 32'h7FF);
        apb(1'b1, ADDR_FORCE, (32'h1 << SRC_LVB) | (32'h1 << SRC_TIMER));
        wait_irq(VEC_LVB);
        cmd(CMD_ACK);
        frc(SRC_ELR);
        quiet();
        cmd(CMD_RTI);
        wait_irq(VEC_ELR);
        serve();
        wait_irq(VEC_TIMER);
        cmd(CMD_ACK);
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_NEST);
        frc(SRC_ELR);
        wait_irq(VEC_ELR);
        serve();
        cmd(CMD_RTI);
        quiet();
        $display("t_prio end");
    endtask
    task automatic t_mask();
        apb(1'b1, ADDR_MASK, 32'h0);
        frc(SRC_TIMER);
        quiet();
        frc(SRC_PWD);
        wait_irq(VEC_PWD);
        serve();
        apb(1'b1, ADDR_FORCE, 32'h1 << (16 + SRC_TIMER));
        apb(1'b1, ADDR_MASK, 32'h7FF);
        quiet();
        cmd(CMD_DIS);
        frc(SRC_LVA);
        frc(SRC_PWD);
        quiet();
        cmd(CMD_ENA);
        wait_irq(VEC_PWD);
        serve();
        wait_irq(VEC_LVA);
        serve();
        $display("t_mask end");
    endtask
    task automatic pin_irq(input logic [6:0] w, input logic [VEC_W-1:0] v);
        @(posedge pclk);
        want <= w;
        repeat (6) @(posedge pclk);
        want <= 7'h00;
        wait_irq(v);
        serve();
        quiet();
    endtask
    task automatic t_pins();
        pin_irq(7'h02, VEC_LVA);
        pin_irq(7'h08, VEC_EDGE);
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_ELR_EDGE);
        pin_irq(7'h01, VEC_ELR);
        apb(1'b1, ADDR_CTRL, (32'h1 << CTRL_SPB_IRQ) | (32'h1 << CTRL_CLKO_DIS));
        pin_irq(7'h20, VEC_SPB_TX);
        apb(1'b1, ADDR_CTRL, 32'h0);
        @(posedge pclk);
        pulse <= 6'h04;
        @(posedge pclk);
        pulse <= 6'h00;
        wait_irq(VEC_SPA_TX);
        serve();
        cmd(CMD_PWD_ENTER);
        frc(SRC_PWD);
        repeat (195) @(posedge pclk);
        chk(core_run, 1'b0);
        wait_irq(VEC_PWD);
        serve();
        $display("t_pins end");
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_prio();
        t_mask();
        t_pins();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        wrap_up();
    end
endmodule
